/* File: logic/asfh_consts.vh */
`ifndef ASFH_CONSTS_VH
`define ASFH_CONSTS_VH

// Register byte offsets
`define ASFH_OFS_CTRL    8'h00
`define ASFH_OFS_STATUS  8'h04
`define ASFH_OFS_WDATA   8'h08
`define ASFH_OFS_CMD     8'h0c
`define ASFH_OFS_RDATA   8'h10
`define ASFH_OFS_WCOUNT  8'h14

// CTRL fields
`define ASFH_CTRL_EXP    0
`define ASFH_CTRL_FL     1
// CMD fields
`define ASFH_CMD_WRITE   0
`define ASFH_CMD_READ    1
`define ASFH_CMD_RESET   2
`define ASFH_CMD_REWIND  3
// STATUS fields
`define ASFH_ST_BUSY     0
`define ASFH_ST_EMPTY    1
`define ASFH_ST_FULL     2
`define ASFH_ST_HALF     3
`define ASFH_ST_REFUSED  4
`define ASFH_ST_READY    5
`define ASFH_ST_RWOK     6

// Reset values
`define ASFH_CTRL_RST    2'h0
`define ASFH_WDATA_RST   9'h000

// Timing, ns as printed for the slowest grade
`define ASFH_CLK_NS      4
`define ASFH_T_PULSE_NS  35
`define ASFH_T_ACCESS_NS 35
`define ASFH_T_FLAG_NS   45
`define ASFH_SYNC_CYC    4
`define ASFH_CYC(ns)     (((ns) + `ASFH_CLK_NS - 1) / `ASFH_CLK_NS)

// Cycle counts derived from the times
`define ASFH_PULSE_CYC   `ASFH_CYC(`ASFH_T_PULSE_NS)
`define ASFH_RDLO_CYC    (`ASFH_CYC(`ASFH_T_ACCESS_NS) + `ASFH_SYNC_CYC)
`define ASFH_SETTLE_CYC  (`ASFH_CYC(`ASFH_T_FLAG_NS) + `ASFH_SYNC_CYC)

`endif

/* File: logic/asfh_sync.v */
`timescale 1ns/1ps
module asfh_sync #(
    parameter WIDTH = 12
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             ce,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;
    integer i;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q     <= {WIDTH{1'b0}};
            s2_q     <= {WIDTH{1'b0}};
            s3_q     <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else if (ce) begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Per bit: a change counts only once stages two and three agree
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    sync_out[i] <= s3_q[i];
                end
            end
        end
    end
endmodule

/* File: logic/asfh_host.v */
`timescale 1ns/1ps
`include "asfh_consts.vh"
module asfh_host #(
    parameter DEPTH = 512,
    parameter CW    = 15
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg  [8:0]  write_data,
    output reg         write_strobe_n,
    output reg         read_strobe_n,
    output reg         reset_low_input,
    output reg         first_load_or_rewind,
    output reg         expansion_input,
    input  wire [8:0]  read_data,
    input  wire        full_indicator,
    input  wire        empty_indicator,
    input  wire        expansion_out_or_halfway
);
    localparam [2:0] S_IDLE   = 3'd0;
    localparam [2:0] S_RST    = 3'd1;
    localparam [2:0] S_WLO    = 3'd2;
    localparam [2:0] S_RLO    = 3'd3;
    localparam [2:0] S_RTLO   = 3'd4;
    localparam [2:0] S_SETTLE = 3'd5;

    localparam integer PULSE_I  = `ASFH_PULSE_CYC - 1;
    localparam integer RDLO_I   = `ASFH_RDLO_CYC - 1;
    localparam integer SETTLE_I = `ASFH_SETTLE_CYC - 1;
    localparam [4:0] PULSE_N  = PULSE_I[4:0];
    localparam [4:0] RDLO_N   = RDLO_I[4:0];
    localparam [4:0] SETTLE_N = SETTLE_I[4:0];
    localparam [CW-1:0] CAP   = DEPTH[CW-1:0];

    wire [11:0] sync_w;
    reg  [2:0]  state_q;
    reg  [4:0]  cnt_q;
    reg  [1:0]  ctrl_q;
    reg  [3:0]  cmd_q;
    reg         cmd_vld_q;
    reg         clr_ref_q;
    reg         refused_q;
    reg         ready_q;
    reg  [8:0]  rdata_q;
    reg  [CW-1:0] wcount_q;

    wire empty_s = ~sync_w[9];
    wire full_s  = ~sync_w[10];
    wire half_s  = ~sync_w[11] & ~ctrl_q[`ASFH_CTRL_EXP];
    wire rw_ok   = ~ctrl_q[`ASFH_CTRL_EXP] & (wcount_q < CAP);
    wire busy    = (state_q != S_IDLE) | cmd_vld_q;

    function [31:0] rd_mux;
        input [7:0] a;
        begin
            case (a)
                `ASFH_OFS_CTRL:   rd_mux = {30'h0, ctrl_q};
                `ASFH_OFS_STATUS: rd_mux = {25'h0, rw_ok, ready_q,
                                            refused_q, half_s, full_s,
                                            empty_s, busy};
                `ASFH_OFS_WDATA:  rd_mux = {23'h0, write_data};
                `ASFH_OFS_RDATA:  rd_mux = {23'h0, rdata_q};
                `ASFH_OFS_WCOUNT: rd_mux = {{(32-CW){1'b0}}, wcount_q};
                default:          rd_mux = 32'h0;
            endcase
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `ASFH_OFS_CTRL) | (a == `ASFH_OFS_STATUS) |
                     (a == `ASFH_OFS_WDATA) | (a == `ASFH_OFS_CMD) |
                     (a == `ASFH_OFS_RDATA) | (a == `ASFH_OFS_WCOUNT);
        end
    endfunction

    asfh_sync #(
        .WIDTH (12)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .async_in ({expansion_out_or_halfway, full_indicator,
                    empty_indicator, read_data}),
        .sync_out (sync_w)
    );

    // APB slave: one wait state, effects at the edge that sees pready
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready          <= 1'b0;
            pslverr         <= 1'b0;
            prdata          <= 32'h0;
            ctrl_q          <= `ASFH_CTRL_RST;
            write_data      <= `ASFH_WDATA_RST;
            cmd_q           <= 4'h0;
            cmd_vld_q       <= 1'b0;
            clr_ref_q       <= 1'b0;
            expansion_input <= 1'b0;
        end else if (ce) begin
            cmd_vld_q       <= 1'b0;
            clr_ref_q       <= 1'b0;
            expansion_input <= ctrl_q[`ASFH_CTRL_EXP];
            if (psel && penable && !pready) begin
                pready  <= 1'b1;
                pslverr <= ~mapped(paddr);
                prdata  <= pwrite ? 32'h0 : rd_mux(paddr);
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
            if (psel && penable && pready && pwrite) begin
                case (paddr)
                    `ASFH_OFS_CTRL: ctrl_q <= pwdata[1:0];
                    `ASFH_OFS_STATUS:
                        clr_ref_q <= pwdata[`ASFH_ST_REFUSED];
                    // Data may only change while no write is on the pins
                    `ASFH_OFS_WDATA: begin
                        if (state_q != S_WLO) begin
                            write_data <= pwdata[8:0];
                        end
                    end
                    `ASFH_OFS_CMD: begin
                        cmd_q     <= pwdata[3:0];
                        cmd_vld_q <= |pwdata[3:0];
                    end
                    default: ;
                endcase
            end
        end
    end

    // Pin sequencer; starts with a reset pulse after power-up
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q              <= S_RST;
            cnt_q                <= PULSE_N;
            reset_low_input      <= 1'b0;
            write_strobe_n       <= 1'b1;
            read_strobe_n        <= 1'b1;
            first_load_or_rewind <= 1'b1;
            refused_q            <= 1'b0;
            ready_q              <= 1'b0;
            rdata_q              <= 9'h000;
            wcount_q             <= {CW{1'b0}};
        end else if (ce) begin
            // Set wins over a software clear in the same cycle
            if (clr_ref_q) begin
                refused_q <= 1'b0;
            end
            if (cnt_q != 5'd0) begin
                cnt_q <= cnt_q - 5'd1;
            end
            case (state_q)
                S_IDLE: begin
                    first_load_or_rewind <= ctrl_q[`ASFH_CTRL_EXP] ?
                        ~ctrl_q[`ASFH_CTRL_FL] : 1'b1;
                    if (cmd_vld_q) begin
                        if (cmd_q[`ASFH_CMD_RESET]) begin
                            state_q         <= S_RST;
                            cnt_q           <= PULSE_N;
                            reset_low_input <= 1'b0;
                            ready_q         <= 1'b0;
                        end else if (cmd_q[`ASFH_CMD_WRITE]) begin
                            if (!ready_q || full_s) begin
                                refused_q <= 1'b1;
                            end else begin
                                state_q        <= S_WLO;
                                cnt_q          <= PULSE_N;
                                write_strobe_n <= 1'b0;
                                if (wcount_q < CAP) begin
                                    wcount_q <= wcount_q + 1'b1;
                                end
                            end
                        end else if (cmd_q[`ASFH_CMD_READ]) begin
                            if (!ready_q || empty_s) begin
                                refused_q <= 1'b1;
                            end else begin
                                state_q       <= S_RLO;
                                cnt_q         <= RDLO_N;
                                read_strobe_n <= 1'b0;
                            end
                        end else if (cmd_q[`ASFH_CMD_REWIND]) begin
                            if (!ready_q || !rw_ok) begin
                                refused_q <= 1'b1;
                            end else begin
                                state_q              <= S_RTLO;
                                cnt_q                <= PULSE_N;
                                first_load_or_rewind <= 1'b0;
                            end
                        end
                    end
                end
                S_RST: begin
                    if (cnt_q == 5'd0) begin
                        reset_low_input <= 1'b1;
                        wcount_q        <= {CW{1'b0}};
                        state_q         <= S_SETTLE;
                        cnt_q           <= SETTLE_N;
                    end
                end
                S_WLO: begin
                    if (cnt_q == 5'd0) begin
                        write_strobe_n <= 1'b1;
                        state_q        <= S_SETTLE;
                        cnt_q          <= SETTLE_N;
                    end
                end
                S_RLO: begin
                    if (cnt_q == 5'd0) begin
                        rdata_q       <= sync_w[8:0];
                        read_strobe_n <= 1'b1;
                        state_q       <= S_SETTLE;
                        cnt_q         <= SETTLE_N;
                    end
                end
                S_RTLO: begin
                    if (cnt_q == 5'd0) begin
                        first_load_or_rewind <= 1'b1;
                        state_q              <= S_SETTLE;
                        cnt_q                <= SETTLE_N;
                    end
                end
                S_SETTLE: begin
                    // Flags need their delay plus the sync before use
                    if (cnt_q == 5'd0) begin
                        ready_q <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
            if (cmd_vld_q && state_q != S_IDLE) begin
                refused_q <= 1'b1;
            end
        end
    end
endmodule

/* File: verification/asfh_fifo_model.sv */
`timescale 1ns/1ps
module asfh_fifo_model #(
    parameter int DEPTH = 512
) (
    input  wire logic [8:0] write_data,
    input  wire logic       write_strobe_n,
    input  wire logic       read_strobe_n,
    input  wire logic       reset_low_input,
    input  wire logic       first_load_or_rewind,
    input  wire logic       expansion_input,
    output logic      [8:0] read_data,
    output logic            full_indicator,
    output logic            empty_indicator,
    output logic            expansion_out_or_halfway
);
    logic [8:0] mem [DEPTH];
    logic [8:0] q = 9'h000;
    logic       hf = 1'b1;
    logic       wok = 1'b0;
    logic       rok = 1'b0;
    int         wp = 0, rp = 0, cnt = 0;

    // No pull on the bus, so a released bus shows the inverse
    assign read_data = (read_strobe_n || !rok) ? ~q : q;
    assign full_indicator = cnt != DEPTH;
    assign empty_indicator = cnt != 0;
    assign expansion_out_or_halfway = expansion_input | hf;

    always @(reset_low_input) begin
        if (!reset_low_input) begin
            wp = 0;
            rp = 0;
            cnt = 0;
            hf = 1'b1;
        end
    end
    always @(negedge write_strobe_n) begin
        wok = reset_low_input && cnt < DEPTH;
        if (wok && cnt >= DEPTH / 2)
            hf = 1'b0;
    end
    always @(posedge write_strobe_n) begin
        if (wok) begin
            mem[wp] = write_data;
            wp = (wp + 1) % DEPTH;
            cnt++;
        end
        wok = 1'b0;
    end
    always @(negedge read_strobe_n) begin
        rok = reset_low_input && cnt != 0;
        if (rok)
            q = mem[rp];
    end
    always @(posedge read_strobe_n) begin
        if (rok) begin
            rp = (rp + 1) % DEPTH;
            cnt--;
            if (cnt <= DEPTH / 2)
                hf = 1'b1;
        end
        rok = 1'b0;
    end
    always @(negedge first_load_or_rewind) begin
        if (!expansion_input && reset_low_input) begin
            rp = 0;
            cnt = wp;
            hf = cnt <= DEPTH / 2;
        end
    end
endmodule

/* File: verification/asfh_checker.sv */
`timescale 1ns/1ps
module asfh_checker (
    input wire       pclk,
    input wire       presetn,
    input wire       pready,
    input wire [8:0] write_data,
    input wire       write_strobe_n,
    input wire       read_strobe_n,
    input wire       reset_low_input,
    input wire       first_load_or_rewind,
    input wire       expansion_input,
    input wire       full_indicator,
    input wire       empty_indicator
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic seen_q;
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            seen_q <= 1'b0;
        else if (reset_low_input)
            seen_q <= 1'b1;

    chk_strobes_at_reset: assert property ((!reset_low_input || $rose(reset_low_input)) |-> write_strobe_n && read_strobe_n) else $error("strobe low near fifo reset");
    chk_write_after_reset: assert property ($fell(write_strobe_n) |-> seen_q) else $error("write before fifo reset");
    chk_rewind_quiet: assert property (!first_load_or_rewind && !expansion_input |-> write_strobe_n && read_strobe_n) else $error("strobe during rewind");
    chk_write_width: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*8] ##1 !write_strobe_n ##1 write_strobe_n) else $error("write pulse width");
    chk_read_width: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*8] ##1 !read_strobe_n [*5] ##1 read_strobe_n) else $error("read pulse width");
    chk_reset_width: assert property ($fell(reset_low_input) |-> !reset_low_input [*8] ##1 !reset_low_input ##1 reset_low_input) else $error("reset pulse width");
    chk_rewind_width: assert property ($fell(first_load_or_rewind) && !expansion_input |-> !first_load_or_rewind [*8] ##1 !first_load_or_rewind ##1 first_load_or_rewind) else $error("rewind pulse width");
    chk_write_not_full: assert property ($fell(write_strobe_n) |-> full_indicator) else $error("write while full");
    chk_read_not_empty: assert property ($fell(read_strobe_n) |-> empty_indicator) else $error("read while empty");
    chk_data_held: assert property (!write_strobe_n && !$past(write_strobe_n) |-> $stable(write_data)) else $error("write data moved");
    chk_pready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
endmodule

bind asfh_host asfh_checker asfh_checker_i (
    .pclk, .presetn, .pready, .write_data, .write_strobe_n, .read_strobe_n,
    .reset_low_input, .first_load_or_rewind, .expansion_input,
    .full_indicator, .empty_indicator
);

/* File: verification/test_asfh_host.sv */
`timescale 1ns/1ps
module test_asfh_host;
    localparam int DEPTH = 16;
    logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [8:0]  write_data, read_data, fifo[$], hist[$];
    logic        pready, pslverr, write_strobe_n, read_strobe_n;
    logic        reset_low_input, first_load_or_rewind, expansion_input;
    logic        full_indicator, empty_indicator, expansion_out_or_halfway;
    logic        err, refused = 1'b0, exp_mode = 1'b0;
    int          n_fail = 0, cmp_count = 0, seed = 2399, cyc = 0, wcount = 0;

    asfh_host #(.DEPTH(DEPTH)) asfh_host_i (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .write_data, .write_strobe_n,
        .read_strobe_n, .reset_low_input, .first_load_or_rewind,
        .expansion_input, .read_data, .full_indicator, .empty_indicator,
        .expansion_out_or_halfway
    );
    asfh_fifo_model #(.DEPTH(DEPTH)) asfh_fifo_model_i (
        .write_data, .write_strobe_n, .read_strobe_n, .reset_low_input,
        .first_load_or_rewind, .expansion_input, .read_data,
        .full_indicator, .empty_indicator, .expansion_out_or_halfway
    );

    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // One wait state: pready seen at the second edge of access
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk("pready_wait", 32'd2, n);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] st_exp();
        int s;
        s = fifo.size();
        return {25'h0, !exp_mode && wcount < DEPTH, 1'b1, refused,
                !exp_mode && s > DEPTH / 2,
                s == DEPTH, s == 0, 1'b0};
    endfunction
    // Polls busy, then compares flags, refusal and write count
    task automatic cmd(input logic [3:0] c, input logic ref_e);
        apb(1'b1, 8'h0c, {28'h0, c});
        do
            apb(1'b0, 8'h04, 32'h0);
        while (rd[0] !== 1'b0);
        refused = ref_e;
        chk("status", st_exp(), rd & 32'h7f);
        apb(1'b0, 8'h14, 32'h0);
        chk("wcount", wcount, rd);
        if (ref_e)
            apb(1'b1, 8'h04, 32'h10);
        refused = 1'b0;
    endtask
    task automatic put(input logic [8:0] v);
        logic ok;
        ok = fifo.size() < DEPTH;
        apb(1'b1, 8'h08, {23'h0, v});
        if (ok) begin
            fifo.push_back(v);
            hist.push_back(v);
            if (wcount < DEPTH)
                wcount++;
        end
        cmd(4'h1, !ok);
    endtask
    task automatic get();
        logic ok;
        logic [8:0] e;
        ok = fifo.size() != 0;
        e = 9'h000;
        if (ok)
            e = fifo.pop_front();
        cmd(4'h2, !ok);
        if (ok) begin
            apb(1'b0, 8'h10, 32'h0);
            chk("rdata", {23'h0, e}, rd);
        end
    endtask
    task automatic rewind();
        logic ok;
        ok = !exp_mode && wcount < DEPTH;
        if (ok)
            fifo = hist;
        cmd(4'h8, !ok);
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        do
            apb(1'b0, 8'h04, 32'h0);
        while (rd[5] !== 1'b1);
        chk("status", st_exp(), rd & 32'h7f);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl", 32'h0, rd);
        apb(1'b0, 8'h18, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        chk("unmapped", 32'h0, rd);
        get();
        $display("test reset_state done");
        repeat (DEPTH + 1) put(9'($random(seed)));
        get();
        put(9'($random(seed)));
        repeat (DEPTH + 1) get();
        rewind();
        $display("test fill_drain done");
        fifo.delete();
        hist.delete();
        wcount = 0;
        cmd(4'h4, 1'b0);
        repeat (5) put(9'($random(seed)));
        repeat (3) get();
        rewind();
        repeat (6) get();
        $display("test rewind done");
        apb(1'b1, 8'h00, 32'h1);
        // Enable low must hold the mode pin at its old level
        ce <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("ce_freeze", 32'h0, {31'h0, expansion_input});
        ce <= 1'b1;
        apb(1'b1, 8'h00, 32'h3);
        exp_mode = 1'b1;
        rewind();
        chk("exp_pin", 32'h1, {31'h0, expansion_input});
        chk("first_load", 32'h0, {31'h0, first_load_or_rewind});
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h00, 32'h0);
        $display("test expansion done");
        wrap_up();
    end
endmodule
